/* File: verilog/ccpwm_pkg.sv */
package ccpwm_pkg;
  // Register word indices (byte addresses are multiples of four: index times four)
  localparam logic [7:0] IDX_VALUE_LOW = 8'h15;
  localparam logic [7:0] IDX_VALUE_HIGH = 8'h16;
  localparam logic [7:0] IDX_UNIT_CONTROL = 8'h17;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h18;
  localparam logic [9:0] ADDR_VALUE_LOW = {IDX_VALUE_LOW, 2'b00};
  localparam logic [9:0] ADDR_VALUE_HIGH = {IDX_VALUE_HIGH, 2'b00};
  localparam logic [9:0] ADDR_UNIT_CONTROL = {IDX_UNIT_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_EVENT_STATUS = {IDX_EVENT_STATUS, 2'b00};
  // Control field layout
  localparam int MODE_LSB = 0;
  localparam int DUTY_LOW_LSB = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h3F;
  // Event status layout
  localparam int EVENT_FLAG_BIT = 0;
  localparam int EVENT_IRQ_EN_BIT = 1;
  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: verilog/ccpwm_unit.sv */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// - Mode zero disables unit, resets state
// - Modes 0100-0111 pick capture edge/prescale
// - 1000/1001 compare drives pin high/low, flags
// - 1010 flags match, pin untouched
// - 1011 flags, clears timer, starts conversion
// - 11xx is 10-bit PWM from period timer
// - Capture copies full 16-bit timer count
// - Capture sets flag; only software clears
// - New capture overwrites unread value
// - Edge detect watches actual pin level
// - Prescaler cleared when off/not capture/reset
// - Capture-to-capture switch keeps prescaler count
// - Compare value with timer every cycle
// - Control write of zero forces latch low
// - Special trigger clear sets no overflow flag
// - Control bits 5:4 are duty low bits
// - Control bits 7:6 read zero
// - Value register is two byte registers
// - Period end clears timer, sets pin if duty nonzero, loads
// - Pin clears when duty equals extended count
// - Duty beyond period never clears pin
// - High byte is read-only duty buffer in PWM modes
module ccpwm_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] firstTimerCount,
  input wire logic [7:0] periodTimerCount,
  input wire logic [7:0] periodRegister,
  input wire logic [1:0] periodTimerSub,
  input wire logic periodTimerInc,
  input wire logic unitPin,
  output logic unitPinOut,
  output logic firstTimerClear,
  output logic periodTimerClear,
  output logic adcStart,
  output logic eventIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] valueLow_r, valueLow_nxt;
  logic [7:0] valueHigh_r, valueHigh_nxt;
  logic [5:0] control_r, control_nxt;
  logic eventFlag_r, eventFlag_nxt;
  logic irqEnable_r, irqEnable_nxt;
  logic outLatch_r, outLatch_nxt;
  logic [1:0] dutyLatch_r, dutyLatch_nxt;
  logic [3:0] prescale_r, prescale_nxt;
  logic pinPrev_r, pinPrev_nxt;
  logic trigClear_r, trigClear_nxt;
  logic trigAdc_r, trigAdc_nxt;
  logic pwmClear_r, pwmClear_nxt;
  logic irqOut_r, irqOut_nxt;

  // Bus slave state
  typedef enum logic [2:0] {
    CCPWM_WR_IDLE = 3'b001,
    CCPWM_WR_RESP = 3'b010,
    CCPWM_WR_WAIT = 3'b100
  } ccpwm_wr_t;
  ccpwm_wr_t wrState_r, wrState_nxt;
  logic awHave_r, awHave_nxt;
  logic wHave_r, wHave_nxt;
  logic [11:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic [1:0] bResp_r, bResp_nxt;
  logic rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0] rResp_r, rResp_nxt;

  // Mode helpers; isCapture and isPwm are used in several places
  function automatic logic isCapture(input logic [3:0] m);
    isCapture = (m[3:2] == 2'b01);
  endfunction

  function automatic logic isCompare(input logic [3:0] m);
    isCompare = (m[3:2] == 2'b10);
  endfunction

  function automatic logic isPwm(input logic [3:0] m);
    isPwm = (m[3:2] == 2'b11);
  endfunction

  // Registers sit on word indices; the two byte-lane address bits are ignored
  function automatic logic hits(input logic [11:0] a, input logic [7:0] idx);
    hits = (a[11:2] == {2'b00, idx});
  endfunction

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = hits(a, ccpwm_pkg::IDX_VALUE_LOW) ||
               hits(a, ccpwm_pkg::IDX_VALUE_HIGH) ||
               hits(a, ccpwm_pkg::IDX_UNIT_CONTROL) ||
               hits(a, ccpwm_pkg::IDX_EVENT_STATUS);
  endfunction

  logic [3:0] mode;
  logic wrFire;
  logic [7:0] wrByte;
  assign mode = control_r[3:0];
  // A write lands only once both halves are held, so bus order does not matter
  assign wrFire = awHave_r && wHave_r && (wrState_r == CCPWM_WR_IDLE);
  assign wrByte = wData_r[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus write/read channels; writes land in one cycle, reads answer next cycle
  always_comb begin
    wrState_nxt = wrState_r;
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bResp_nxt = bResp_r;
    rValid_nxt = rValid_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    // Address and data taken in either order
    if (s_axi_awvalid && !awHave_r) begin
      awHave_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_r) begin
      wHave_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    case (wrState_r)
      CCPWM_WR_IDLE: begin
        if (wrFire) begin
          bResp_nxt = isMapped(awAddr_r) ? ccpwm_pkg::RESP_OKAY : ccpwm_pkg::RESP_SLVERR;
          wrState_nxt = CCPWM_WR_RESP;
        end
      end
      CCPWM_WR_RESP: begin
        if (s_axi_bready) begin
          awHave_nxt = 1'b0;
          wHave_nxt = 1'b0;
          wrState_nxt = CCPWM_WR_WAIT;
        end
      end
      CCPWM_WR_WAIT: wrState_nxt = CCPWM_WR_IDLE;
      default: wrState_nxt = CCPWM_WR_IDLE;
    endcase
    // Read channel: one at a time
    if (rValid_r) begin
      if (s_axi_rready) begin
        rValid_nxt = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      rValid_nxt = 1'b1;
      rResp_nxt = isMapped(s_axi_araddr) ? ccpwm_pkg::RESP_OKAY : ccpwm_pkg::RESP_SLVERR;
      // Unmapped reads return zero together with the error response
      rData_nxt = 32'h0000_0000;
      if (hits(s_axi_araddr, ccpwm_pkg::IDX_VALUE_LOW)) begin
        rData_nxt = {24'h000000, valueLow_r};
      end else if (hits(s_axi_araddr, ccpwm_pkg::IDX_VALUE_HIGH)) begin
        rData_nxt = {24'h000000, valueHigh_r};
      end else if (hits(s_axi_araddr, ccpwm_pkg::IDX_UNIT_CONTROL)) begin
        rData_nxt = {26'h0000000, control_r};
      end else if (hits(s_axi_araddr, ccpwm_pkg::IDX_EVENT_STATUS)) begin
        rData_nxt = {30'h00000000, irqEnable_r, eventFlag_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit behaviour: capture, compare, PWM and register writes
  logic pinRise, pinFall, capEvent, match, pwmPeriodEnd;
  logic [9:0] dutyActive;
  logic [9:0] pwmCountNext;
  assign pinRise = unitPin && !pinPrev_r;
  assign pinFall = !unitPin && pinPrev_r;
  assign match = (firstTimerCount == {valueHigh_r, valueLow_r});
  assign pwmPeriodEnd = periodTimerInc && (periodTimerCount == periodRegister);
  assign dutyActive = {valueHigh_r, dutyLatch_r};
  // The pin latch is registered, so the clear is decided against the count that
  // the next edge brings; otherwise every pulse would run one sub-tick long.
  // Limitation: this assumes the sub-count advances on every clock.
  assign pwmCountNext = {periodTimerCount, periodTimerSub} + 10'h001;

  always_comb begin
    valueLow_nxt = valueLow_r;
    valueHigh_nxt = valueHigh_r;
    control_nxt = control_r;
    eventFlag_nxt = eventFlag_r;
    irqEnable_nxt = irqEnable_r;
    outLatch_nxt = outLatch_r;
    dutyLatch_nxt = dutyLatch_r;
    prescale_nxt = prescale_r;
    pinPrev_nxt = unitPin;
    trigClear_nxt = 1'b0;
    trigAdc_nxt = 1'b0;
    pwmClear_nxt = 1'b0;
    capEvent = 1'b0;
    // Software writes first so hardware events later in the process win
    if (wrFire && wStrb_r[0]) begin
      if (hits(awAddr_r, ccpwm_pkg::IDX_VALUE_LOW)) begin
        valueLow_nxt = wrByte;
      end else if (hits(awAddr_r, ccpwm_pkg::IDX_VALUE_HIGH) && !isPwm(mode)) begin
        valueHigh_nxt = wrByte;
      end else if (hits(awAddr_r, ccpwm_pkg::IDX_UNIT_CONTROL)) begin
        control_nxt = wrByte[5:0] & ccpwm_pkg::CONTROL_WMASK[5:0];
        // Direct switch between capture settings keeps the count
        if (!(isCapture(wrByte[3:0]) && isCapture(mode))) begin
          prescale_nxt = 4'h0;
        end
        if (wrByte[5:0] == 6'h00) begin
          outLatch_nxt = 1'b0;
        end
      end else if (hits(awAddr_r, ccpwm_pkg::IDX_EVENT_STATUS)) begin
        if (!wrByte[ccpwm_pkg::EVENT_FLAG_BIT]) begin
          eventFlag_nxt = 1'b0;
        end
        irqEnable_nxt = wrByte[ccpwm_pkg::EVENT_IRQ_EN_BIT];
      end
    end
    // Mode actions follow the mode held before this cycle's control write
    case (mode)
      ccpwm_pkg::MODE_CAP_FALL: capEvent = pinFall;
      ccpwm_pkg::MODE_CAP_RISE: capEvent = pinRise;
      ccpwm_pkg::MODE_CAP_RISE4, ccpwm_pkg::MODE_CAP_RISE16: begin
        if (pinRise) begin
          // Count rises; fire on the 4th or 16th
          if ((mode == ccpwm_pkg::MODE_CAP_RISE4 && prescale_r[1:0] == 2'b11) ||
              (mode == ccpwm_pkg::MODE_CAP_RISE16 && prescale_r == 4'hF)) begin
            capEvent = 1'b1;
            prescale_nxt = 4'h0;
          end else begin
            prescale_nxt = prescale_r + 4'h1;
          end
        end
      end
      ccpwm_pkg::MODE_CMP_SET, ccpwm_pkg::MODE_CMP_CLR, ccpwm_pkg::MODE_CMP_SOFT,
      ccpwm_pkg::MODE_CMP_SPECIAL: begin
        if (match) begin
          eventFlag_nxt = 1'b1;
          if (mode == ccpwm_pkg::MODE_CMP_SET) outLatch_nxt = 1'b1;
          if (mode == ccpwm_pkg::MODE_CMP_CLR) outLatch_nxt = 1'b0;
          if (mode == ccpwm_pkg::MODE_CMP_SPECIAL) begin
            // Clear pulse only; the timer's overflow flag is not touched
            trigClear_nxt = 1'b1;
            trigAdc_nxt = 1'b1;
          end
        end
      end
      default: begin
        if (isPwm(mode)) begin
          if (pwmPeriodEnd) begin
            pwmClear_nxt = 1'b1;
            valueHigh_nxt = valueLow_r;
            dutyLatch_nxt = control_r[5:4];
            outLatch_nxt = ({valueLow_r, control_r[5:4]} != 10'h000);
          end else if (dutyActive == pwmCountNext) begin
            // Duty above period never meets the count, so pin stays high
            outLatch_nxt = 1'b0;
          end
        end
      end
    endcase
    if (capEvent) begin
      valueHigh_nxt = firstTimerCount[15:8];
      valueLow_nxt = firstTimerCount[7:0];
      eventFlag_nxt = 1'b1;
    end
    // Off, reserved codes or non-capture modes hold the prescaler clear
    if (!isCapture(control_nxt[3:0])) begin
      prescale_nxt = 4'h0;
    end
    if (control_nxt[3:0] == ccpwm_pkg::MODE_OFF) begin
      outLatch_nxt = 1'b0;
      dutyLatch_nxt = 2'b00;
    end
    irqOut_nxt = eventFlag_nxt && irqEnable_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      valueLow_r <= 8'h00;
      valueHigh_r <= 8'h00;
      control_r <= ccpwm_pkg::CONTROL_RESET[5:0];
      eventFlag_r <= 1'b0;
      irqEnable_r <= 1'b0;
      outLatch_r <= 1'b0;
      dutyLatch_r <= 2'b00;
      prescale_r <= 4'h0;
      pinPrev_r <= 1'b0;
      trigClear_r <= 1'b0;
      trigAdc_r <= 1'b0;
      pwmClear_r <= 1'b0;
      irqOut_r <= 1'b0;
      wrState_r <= CCPWM_WR_IDLE;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 12'h000;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      bResp_r <= 2'b00;
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= 2'b00;
    end else begin
      valueLow_r <= valueLow_nxt;
      valueHigh_r <= valueHigh_nxt;
      control_r <= control_nxt;
      eventFlag_r <= eventFlag_nxt;
      irqEnable_r <= irqEnable_nxt;
      outLatch_r <= outLatch_nxt;
      dutyLatch_r <= dutyLatch_nxt;
      prescale_r <= prescale_nxt;
      pinPrev_r <= pinPrev_nxt;
      trigClear_r <= trigClear_nxt;
      trigAdc_r <= trigAdc_nxt;
      pwmClear_r <= pwmClear_nxt;
      irqOut_r <= irqOut_nxt;
      wrState_r <= wrState_nxt;
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bResp_r <= bResp_nxt;
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = !awHave_r;
  assign s_axi_wready = !wHave_r;
  assign s_axi_bvalid = (wrState_r == CCPWM_WR_RESP);
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign unitPinOut = outLatch_r;
  assign firstTimerClear = trigClear_r;
  assign periodTimerClear = pwmClear_r;
  assign adcStart = trigAdc_r;
  assign eventIrq = irqOut_r;

endmodule
`default_nettype wire

/* File: test/ccpwm_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module ccpwm_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic firstTimerClear,
  input wire logic adcStart,
  input wire logic periodTimerClear
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Both write halves taken on one edge
  sequence writeTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence readTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WRITE_ANSWER: assert property (writeTaken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_READ_ANSWER: assert property (readTaken |=> s_axi_rvalid)
    else $error("read response late");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  AST_READ_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_ARREADY_IDLE: assert property (s_axi_arready != s_axi_rvalid)
    else $error("read slot state wrong");
  AST_TRIG_ADC: assert property (firstTimerClear == adcStart)
    else $error("conversion start not paired with timer clear");
  AST_MODE_EXCLUSIVE: assert property (!(firstTimerClear && periodTimerClear))
    else $error("special trigger during pulse mode");
endmodule
bind ccpwm_unit ccpwm_monitor ccpwm_monitor_inst (.clk_sys(clk_sys), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .firstTimerClear(firstTimerClear),
  .adcStart(adcStart), .periodTimerClear(periodTimerClear));
`default_nettype wire

/* File: test/ccpwm_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ccpwm_pin_model (
  input wire logic extLevel,
  input wire logic dirOut,
  input wire logic useUnit,
  input wire logic portLatch,
  input wire logic unitPinOut,
  output logic unitPin
);
  // Pad level; as an output the port latch can toggle it and cause a capture
  assign unitPin = !dirOut ? extLevel : (useUnit ? unitPinOut : portLatch);
endmodule
`default_nettype wire

/* File: test/test_capture_compare_pwm_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module test_capture_compare_pwm_unit;
  localparam logic [9:0] ADDR_LO = ccpwm_pkg::ADDR_VALUE_LOW;
  localparam logic [9:0] ADDR_HI = ccpwm_pkg::ADDR_VALUE_HIGH;
  localparam logic [9:0] ADDR_CTL = ccpwm_pkg::ADDR_UNIT_CONTROL;
  localparam logic [9:0] ADDR_EVT = ccpwm_pkg::ADDR_EVENT_STATUS;
  logic clk_sys, rst, awValid, wValid, bReady, arValid, rReady, awReady, wReady, bValid;
  logic arReady, rValid, pinOut, tmrClr, prdClr, adcGo, irq, prdInc, timerRun;
  logic extLevel, dirOut, useUnit, portLatch, unitPin;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData, d;
  logic [1:0] bResp, rResp, resp, prdSub;
  logic [15:0] first_timer_count;
  logic [7:0] prdCnt, prdReg;
  int mismatches, check_count, cycles, trigs, clrs, highs, adcs;
  ccpwm_unit ccpwm_unit_inst (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .firstTimerCount(first_timer_count), .periodTimerCount(prdCnt), .periodRegister(prdReg),
    .periodTimerSub(prdSub), .periodTimerInc(prdInc), .unitPin(unitPin), .unitPinOut(pinOut),
    .firstTimerClear(tmrClr), .periodTimerClear(prdClr), .adcStart(adcGo), .eventIrq(irq));
  ccpwm_pin_model ccpwm_pin_model_inst (.extLevel(extLevel), .dirOut(dirOut),
    .useUnit(useUnit), .portLatch(portLatch), .unitPinOut(pinOut), .unitPin(unitPin));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Timers run synchronously to the core clock; first timer only moves when released
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    prdSub <= prdSub + 2'h1;
    prdInc <= prdSub == 2'h2;
    if (prdInc) prdCnt <= (prdCnt == prdReg) ? 8'h00 : prdCnt + 8'h01;
    if (timerRun) first_timer_count <= tmrClr ? 16'h0000 : first_timer_count + 16'h0001;
    if (tmrClr) trigs <= trigs + 1;
    if (adcGo) adcs <= adcs + 1;
    if (prdClr) clrs <= clrs + 1;
    if (pinOut) highs <= highs + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bus master; one edge passes first so no strobe is assigned twice in a step
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    awAddr <= {2'h0, a};
    wData <= {24'h000000, v};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!bValid);
    resp = bResp;
    bReady <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys);
    arAddr <= {2'h0, a};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arValid && arReady) arValid <= 1'b0;
    end while (!rValid);
    d = rData;
    resp = rResp;
    rReady <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Full pulses on the pad, two cycles per level so each edge is sampled
  task automatic edges(input int n);
    repeat (n) begin
      extLevel <= 1'b1;
      repeat (2) @(posedge clk_sys);
      extLevel <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_CTL);
    chk(d, 32'h00000000);
    wr(ADDR_CTL, 8'hFF);
    rd(ADDR_CTL);
    chk(d, 32'h0000003F);
    chk(32'(resp), 32'(ccpwm_pkg::RESP_OKAY));
    wr(10'h3F0, 8'h55);
    chk(32'(resp), 32'(ccpwm_pkg::RESP_SLVERR));
    rd(10'h3F0);
    chk(32'(resp), 32'(ccpwm_pkg::RESP_SLVERR));
    chk(d, 32'h00000000);
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_CTL, 8'(m));
      wr(ADDR_EVT, 8'h00);
      edges(2);
      rd(ADDR_EVT);
      chk(32'(d[0]), 32'h0);
    end
    wr(ADDR_CTL, 8'h00);
    rd(ADDR_CTL);
    chk(d, 32'h00000000);
    $display("register test done");
  endtask
  task automatic t_capture();
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 16'h1234 * 16'(i + 1);
      first_timer_count <= v;
      wr(ADDR_CTL, 8'h00);
      wr(ADDR_CTL, 8'h04 + 8'(i));
      wr(ADDR_EVT, 8'h00);
      edges(i < 2 ? 0 : (i == 2 ? 3 : 15));
      rd(ADDR_EVT);
      chk(32'(d[0]), 32'h0);
      edges(1);
      rd(ADDR_EVT);
      chk(32'(d[0]), 32'h1);
      rd(ADDR_LO);
      chk(d, 32'(v[7:0]));
      rd(ADDR_HI);
      chk(d, 32'(v[15:8]));
    end
    wr(ADDR_CTL, 8'h00);
    wr(ADDR_CTL, 8'h05);
    dirOut <= 1'b1;
    wr(ADDR_EVT, 8'h00);
    portLatch <= 1'b1;
    rd(ADDR_EVT);
    chk(32'(d[0]), 32'h1);
    dirOut <= 1'b0;
    $display("capture test done");
  endtask
  task automatic t_compare();
    logic [3:0] md [5] = '{4'h8, 4'hA, 4'hB, 4'h9, 4'h8};
    logic ex [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    int t0, a0;
    wr(ADDR_CTL, 8'h00);
    dirOut <= 1'b1;
    useUnit <= 1'b1;
    wr(ADDR_LO, 8'h40);
    wr(ADDR_HI, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTL, {4'h0, md[i]});
      wr(ADDR_EVT, 8'h02);
      t0 = trigs;
      a0 = adcs;
      first_timer_count <= 16'h0000;
      timerRun <= 1'b1;
      repeat (80) @(posedge clk_sys);
      timerRun <= 1'b0;
      chk(32'(pinOut), 32'(ex[i]));
      rd(ADDR_EVT);
      chk(32'(d[0]), 32'h1);
      chk(32'(irq), 32'h1);
      chk(32'(trigs - t0), (i == 2) ? 32'h1 : 32'h0);
      chk(32'(adcs - a0), (i == 2) ? 32'h1 : 32'h0);
    end
    wr(ADDR_CTL, 8'h00);
    chk(32'(pinOut), 32'h0);
    wr(ADDR_EVT, 8'h02);
    chk(32'(irq), 32'h0);
    $display("compare test done");
  endtask
  task automatic t_pwm();
    logic [9:0] duty [3] = '{10'h009, 10'h000, 10'h3FC};
    int ex [3] = '{18, 0, 40};
    int h0, c0;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_LO, duty[i][9:2]);
      wr(ADDR_CTL, {2'h0, duty[i][1:0], 4'hC});
      wr(ADDR_HI, 8'h77);
      repeat (60) @(posedge clk_sys);
      h0 = highs;
      c0 = clrs;
      repeat (40) @(posedge clk_sys);
      chk(32'(highs - h0), 32'(ex[i]));
      chk(32'(clrs - c0), 32'h2);
      rd(ADDR_HI);
      chk(d, 32'(duty[i][9:2]));
    end
    $display("pwm test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {awValid, wValid, bReady, arValid, rReady, prdInc, timerRun} = '0;
    {extLevel, dirOut, useUnit, portLatch} = '0;
    {awAddr, arAddr, wData, prdSub, first_timer_count, prdCnt} = '0;
    prdReg = 8'h04;
    {mismatches, check_count, cycles, trigs, clrs, highs, adcs} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_capture();
    t_compare();
    t_pwm();
    tally_and_finish();
  end
endmodule
`default_nettype wire
